//--- src/wdw_pkg.sv
// Constants, types and functions shared by the windowed watchdog
package wdw_pkg;
   // ==========================================
   // Register map
   localparam logic [7:0] ADDR_CONFIG = 8'h00;
   localparam logic [7:0] ADDR_EXT_CONFIG = 8'h04;
   localparam logic [7:0] ADDR_CLEAR = 8'h08;
   localparam logic [7:0] ADDR_UNLOCK = 8'h0C;
   localparam logic [7:0] ADDR_STATUS = 8'h10;
   localparam int ADDR_W = 8;
   // ==========================================
   // Field positions and reset values
   localparam int CFG_DIS_BIT = 7;
   localparam int CFG_STOP_ENTRY_RESET_ENABLE_BIT = 6;
   localparam int CFG_CS_LSB = 4;
   localparam int EXT_WE_BIT = 4;
   localparam int STAT_LOCK_LSB = 24;
   localparam int STAT_WAIT_BIT = 26;
   localparam logic [3:0] UPPER_RESET = 4'h4;
   localparam logic [3:0] LOWER_RESET = 4'h0;
   localparam logic [1:0] CS_RESET = 2'h0;
   localparam logic [7:0] PATTERN_ZERO = 8'h00;
   localparam logic [7:0] UNLOCK_KEY1 = 8'hA5;
   localparam logic [7:0] UNLOCK_KEY2 = 8'h5A;
   // ==========================================
   // Counter and clock source encodings
   localparam int CNT_W = 23;
   localparam int BASE_EXP = 8;
   localparam logic [1:0] CS_RC_FREE = 2'h0;
   localparam logic [1:0] CS_RC_FIXED = 2'h1;
   localparam logic [1:0] CS_MAIN = 2'h2;
   localparam logic [1:0] CS_SUB = 2'h3;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   typedef enum logic [1:0] {
      WDW_FRESH = 2'b00,
      WDW_KEY1 = 2'b01,
      WDW_UNLOCKED = 2'b10,
      WDW_LOCKED = 2'b11
   } wdw_lock_e;
   // Interval length in ticks for a select value
   function automatic logic [CNT_W:0] wdw_limit(input logic [3:0] sel);
      wdw_limit = (CNT_W + 1)'(1) << (BASE_EXP + int'(sel));
   endfunction : wdw_limit
endpackage : wdw_pkg

//--- src/wdw_watchdog.sv
// Windowed watchdog with unlock scheme and AXI4-Lite register slave
`timescale 1ns/100ps
module wdw_watchdog
   import wdw_pkg::*;
(
   input wire logic clk,
   input wire logic reset_n,
   input wire logic [ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic rc_osc_tick,
   input wire logic main_osc_tick,
   input wire logic sub_osc_tick,
   input wire logic rc_osc_enable,
   input wire logic main_osc_enable,
   input wire logic sub_osc_enable,
   input wire logic rc_clock_ready,
   input wire logic main_clock_ready,
   input wire logic sub_clock_ready,
   input wire logic [1:0] bus_clock_source_select,
   input wire logic rc_freq_change,
   input wire logic stop_request,
   input wire logic stop_mode,
   output logic wdt_reset_req
);
   // ==========================================
   // Bus handshake state
   logic aw_held;
   logic w_held;
   logic [ADDR_W-1:0] aw_addr;
   logic [7:0] w_data;
   logic w_lane0;
   logic do_write;
   logic do_read;
   logic [31:0] rd_value;
   logic rd_mapped;
   logic wr_mapped;
   // ==========================================
   // Configuration and watchdog state
   wdw_lock_e lock_state;
   logic act_dis;
   logic act_stop_entry_reset_enable;
   logic [1:0] act_cs;
   logic [3:0] act_upper;
   logic act_we;
   logic [3:0] act_lower;
   logic pend_dis;
   logic pend_stop_entry_reset_enable;
   logic [1:0] pend_cs;
   logic [3:0] pend_upper;
   logic pend_we;
   logic [3:0] pend_lower;
   logic zero_mode;
   logic [7:0] pattern;
   logic [CNT_W-1:0] count;
   logic resume_wait;
   logic src_enable_q;
   // ==========================================
   // Decoded events
   logic clear_write;
   logic activate;
   logic cnt_clear;
   logic pat_update;
   logic violation;
   logic tick;
   logic src_enable;
   logic src_ready;
   logic bus_ready;
   logic run;
   logic in_window;
   logic [CNT_W:0] count_ext;

   function automatic logic wdw_is_wdt_reg(input logic [ADDR_W-1:0] a);
      wdw_is_wdt_reg = (a == ADDR_CONFIG) || (a == ADDR_EXT_CONFIG) ||
         (a == ADDR_CLEAR) || (a == ADDR_UNLOCK);
   endfunction : wdw_is_wdt_reg

   function automatic logic wdw_mapped(input logic [ADDR_W-1:0] a);
      wdw_mapped = wdw_is_wdt_reg(a) || (a == ADDR_STATUS);
   endfunction : wdw_mapped

   // ==========================================
   // AXI4-Lite write channels
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         s_axi_awready <= 1'b0;
         aw_held <= 1'b0;
         aw_addr <= '0;
      end else begin
         s_axi_awready <= s_axi_awvalid && !s_axi_awready && !aw_held && !s_axi_bvalid;
         if (s_axi_awvalid && s_axi_awready) begin
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr;
         end else if (do_write) begin
            aw_held <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         s_axi_wready <= 1'b0;
         w_held <= 1'b0;
         w_data <= '0;
         w_lane0 <= 1'b0;
      end else begin
         s_axi_wready <= s_axi_wvalid && !s_axi_wready && !w_held && !s_axi_bvalid;
         if (s_axi_wvalid && s_axi_wready) begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata[7:0];
            w_lane0 <= s_axi_wstrb[0];
         end else if (do_write) begin
            w_held <= 1'b0;
         end
      end
   end

   assign do_write = aw_held && w_held && !s_axi_bvalid;
   assign wr_mapped = wdw_mapped(aw_addr);

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= RESP_OKAY;
      end else if (do_write) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // ==========================================
   // AXI4-Lite read channels
   assign do_read = s_axi_arvalid && s_axi_arready;
   assign rd_mapped = wdw_mapped(s_axi_araddr);

   always_comb begin
      rd_value = '0;
      if (s_axi_araddr == ADDR_CONFIG) begin
         rd_value[7:0] = {act_dis, act_stop_entry_reset_enable, act_cs, act_upper};
      end else if (s_axi_araddr == ADDR_EXT_CONFIG) begin
         rd_value[EXT_WE_BIT:0] = {act_we, act_lower};
      end else if (s_axi_araddr == ADDR_CLEAR) begin
         rd_value[7:0] = pattern;
      end else if (s_axi_araddr == ADDR_STATUS) begin
         rd_value[CNT_W-1:0] = count;
         rd_value[STAT_LOCK_LSB+1:STAT_LOCK_LSB] = lock_state;
         rd_value[STAT_WAIT_BIT] = resume_wait;
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= '0;
         s_axi_rresp <= RESP_OKAY;
      end else begin
         s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
         if (do_read) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_value;
            s_axi_rresp <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
         end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   // ==========================================
   // Unlock and lock sequencing
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         lock_state <= WDW_FRESH;
      end else begin
         case (lock_state)
            WDW_FRESH, WDW_KEY1: begin
               if (do_write && wdw_is_wdt_reg(aw_addr)) begin
                  if (aw_addr == ADDR_UNLOCK && w_lane0 && lock_state == WDW_FRESH &&
                      w_data == UNLOCK_KEY1) begin
                     lock_state <= WDW_KEY1;
                  end else if (aw_addr == ADDR_UNLOCK && w_lane0 &&
                               lock_state == WDW_KEY1 && w_data == UNLOCK_KEY2) begin
                     lock_state <= WDW_UNLOCKED;
                  end else begin
                     lock_state <= WDW_LOCKED;
                  end
               end else if (do_read && wdw_is_wdt_reg(s_axi_araddr)) begin
                  lock_state <= WDW_LOCKED;
               end
            end
            WDW_UNLOCKED: begin
               if (activate) begin
                  lock_state <= WDW_LOCKED;
               end
            end
            default: begin
               lock_state <= WDW_LOCKED;
            end
         endcase
      end
   end

   // ==========================================
   // Pending and active configuration
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         {pend_dis, pend_stop_entry_reset_enable, pend_cs, pend_upper} <= {1'b0, 1'b0, CS_RESET, UPPER_RESET};
         {pend_we, pend_lower} <= {1'b0, LOWER_RESET};
      end else if (do_write && w_lane0 && lock_state == WDW_UNLOCKED) begin
         if (aw_addr == ADDR_CONFIG) begin
            pend_dis <= w_data[CFG_DIS_BIT];
            pend_stop_entry_reset_enable <= w_data[CFG_STOP_ENTRY_RESET_ENABLE_BIT];
            pend_cs <= w_data[CFG_CS_LSB+1:CFG_CS_LSB];
            pend_upper <= w_data[3:0];
         end else if (aw_addr == ADDR_EXT_CONFIG) begin
            pend_we <= w_data[EXT_WE_BIT];
            pend_lower <= w_data[3:0];
         end
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         {act_dis, act_stop_entry_reset_enable, act_cs, act_upper} <= {1'b0, 1'b0, CS_RESET, UPPER_RESET};
         {act_we, act_lower} <= {1'b0, LOWER_RESET};
      end else if (activate) begin
         {act_dis, act_stop_entry_reset_enable, act_cs, act_upper} <= {pend_dis, pend_stop_entry_reset_enable, pend_cs, pend_upper};
         {act_we, act_lower} <= {pend_we, pend_lower};
      end
   end

   // ==========================================
   // Clear mode and stored pattern
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         zero_mode <= 1'b1;
         pattern <= PATTERN_ZERO;
      end else if (activate) begin
         zero_mode <= (w_data == PATTERN_ZERO);
         pattern <= w_data;
      end else if (pat_update) begin
         pattern <= w_data;
      end
   end

   // ==========================================
   // Clock source selection and Stop handling
   always_comb begin
      case (act_cs)
         CS_MAIN: begin
            tick = main_osc_tick;
            src_enable = main_osc_enable;
            src_ready = main_clock_ready;
         end
         CS_SUB: begin
            tick = sub_osc_tick;
            src_enable = sub_osc_enable;
            src_ready = sub_clock_ready;
         end
         default: begin
            tick = rc_osc_tick;
            src_enable = rc_osc_enable;
            src_ready = rc_clock_ready;
         end
      endcase
      case (bus_clock_source_select)
         CS_MAIN: bus_ready = main_clock_ready;
         CS_SUB: bus_ready = sub_clock_ready;
         default: bus_ready = rc_clock_ready;
      endcase
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         resume_wait <= 1'b0;
      end else if (stop_mode) begin
         resume_wait <= 1'b1;
      end else if (src_ready && bus_ready) begin
         resume_wait <= 1'b0;
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         src_enable_q <= 1'b0;
      end else begin
         src_enable_q <= src_enable;
      end
   end

   // Sleep and Timer modes are invisible here, so counting goes on
   assign run = !act_dis && !stop_mode && !resume_wait;

   // ==========================================
   // Clear decoding and violations
   assign count_ext = {1'b0, count};
   assign clear_write = do_write && w_lane0 && aw_addr == ADDR_CLEAR;
   assign activate = clear_write && lock_state == WDW_UNLOCKED;
   assign in_window = !act_we || count_ext >= wdw_limit(act_lower);

   always_comb begin
      cnt_clear = 1'b0;
      pat_update = 1'b0;
      violation = 1'b0;
      if (activate) begin
         if (!pend_dis) begin
            if ((pend_cs == CS_MAIN && !main_clock_ready) ||
                (pend_cs == CS_SUB && !sub_clock_ready)) begin
               violation = 1'b1;
            end
            if (count_ext > wdw_limit(pend_upper) - (CNT_W + 1)'(1)) begin
               violation = 1'b1;
            end
         end
      end else if (clear_write && !act_dis) begin
         if (!in_window) begin
            violation = 1'b1;
         end else if (zero_mode) begin
            if (w_data == PATTERN_ZERO) begin
               cnt_clear = 1'b1;
            end else begin
               violation = 1'b1;
            end
         end else if (w_data == pattern) begin
            cnt_clear = 1'b0;
         end else if (w_data == ~pattern) begin
            cnt_clear = 1'b1;
            pat_update = 1'b1;
         end else begin
            violation = 1'b1;
         end
      end
      if (!act_dis) begin
         if (run && tick && count_ext == wdw_limit(act_upper) - (CNT_W + 1)'(1)) begin
            violation = 1'b1;
         end
         if (src_enable_q && !src_enable && !stop_mode && !resume_wait) begin
            violation = 1'b1;
         end
         if (rc_freq_change && act_cs == CS_RC_FIXED) begin
            violation = 1'b1;
         end
         if (stop_request && act_stop_entry_reset_enable) begin
            violation = 1'b1;
         end
      end
   end

   // ==========================================
   // Counter
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         count <= '0;
      end else if (cnt_clear) begin
         count <= '0;
      end else if (run && tick) begin
         count <= count + CNT_W'(1);
      end
   end

   // ==========================================
   // Reset request, held until system reset
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         wdt_reset_req <= 1'b0;
      end else if (violation) begin
         wdt_reset_req <= 1'b1;
      end
   end
endmodule : wdw_watchdog

//--- verif/wdw_monitor.sv
// Checker of bus handshake and reset request timing
`timescale 1ns/100ps
module wdw_monitor
(
   input wire logic clk,
   input wire logic reset_n,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wready,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic wdt_reset_req
);
   default clocking @(posedge clk);
   endclocking
   default disable iff (!reset_n);
   // ==========================================
   // Register bus
   property p_aw_ready;
      $rose(s_axi_awvalid) && !s_axi_bvalid |=> s_axi_awready;
   endproperty
   a_aw_ready: assert property (p_aw_ready) else $error("write address not taken");
   property p_ar_ready;
      $rose(s_axi_arvalid) && !s_axi_rvalid |=> s_axi_arready;
   endproperty
   a_ar_ready: assert property (p_ar_ready) else $error("read address not taken");
   property p_w_pulse;
      s_axi_wready |=> !s_axi_wready;
   endproperty
   a_w_pulse: assert property (p_w_pulse) else $error("write ready held");
   property p_b_lat;
      s_axi_awready && s_axi_wready |-> ##2 s_axi_bvalid;
   endproperty
   a_b_lat: assert property (p_b_lat) else $error("write response late");
   property p_b_done;
      s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid;
   endproperty
   a_b_done: assert property (p_b_done) else $error("write response repeated");
   property p_r_lat;
      s_axi_arready |=> s_axi_rvalid;
   endproperty
   a_r_lat: assert property (p_r_lat) else $error("read data late");
   property p_r_done;
      s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid;
   endproperty
   a_r_done: assert property (p_r_done) else $error("read data repeated");
   // ==========================================
   // Reset request
   property p_sticky;
      wdt_reset_req |=> wdt_reset_req;
   endproperty
   a_sticky: assert property (p_sticky) else $error("reset request dropped");
endmodule : wdw_monitor

bind wdw_watchdog wdw_monitor mon (.clk, .reset_n, .s_axi_awvalid, .s_axi_awready,
   .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
   .s_axi_rvalid, .s_axi_rready, .wdt_reset_req);

//--- verif/wdw_osc_model.sv
// Oscillator model giving one count tick per clock while running
`timescale 1ns/100ps
module wdw_osc_model
(
   input wire logic clk,
   input wire logic reset_n,
   input wire logic stop_mode,
   input wire logic rc_osc_enable,
   input wire logic main_osc_enable,
   input wire logic sub_osc_enable,
   input wire logic rc_clock_ready,
   input wire logic main_clock_ready,
   input wire logic sub_clock_ready,
   output logic rc_osc_tick,
   output logic main_osc_tick,
   output logic sub_osc_tick
);
   // All oscillators halt in Stop; unready ones give no ticks
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         rc_osc_tick <= 1'b0;
         main_osc_tick <= 1'b0;
         sub_osc_tick <= 1'b0;
      end else begin
         rc_osc_tick <= rc_osc_enable && rc_clock_ready && !stop_mode;
         main_osc_tick <= main_osc_enable && main_clock_ready && !stop_mode;
         sub_osc_tick <= sub_osc_enable && sub_clock_ready && !stop_mode;
      end
   end
endmodule : wdw_osc_model

//--- verif/tb_top.sv
// Self-checking bench for the windowed watchdog
`timescale 1ns/100ps
module tb_top
   import wdw_pkg::*;
;
   logic clk = 1'b0;
   logic reset_n = 1'b0;
   logic [ADDR_W-1:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd_val;
   logic [3:0] s_axi_wstrb = 4'hF;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic rc_osc_enable = 1'b1, main_osc_enable = 1'b1, sub_osc_enable = 1'b1;
   logic rc_clock_ready = 1'b1, main_clock_ready = 1'b1, sub_clock_ready = 1'b1;
   logic [1:0] bus_clock_source_select = 2'h0, s_axi_bresp, s_axi_rresp;
   logic rc_freq_change = 1'b0, stop_request = 1'b0, stop_mode = 1'b0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic wdt_reset_req, rc_osc_tick, main_osc_tick, sub_osc_tick;
   int errors = 0;
   int checked = 0;

   always #2 clk = ~clk;

   wdw_watchdog dut (.clk, .reset_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
      .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .rc_osc_tick, .main_osc_tick,
      .sub_osc_tick, .rc_osc_enable, .main_osc_enable, .sub_osc_enable, .rc_clock_ready,
      .main_clock_ready, .sub_clock_ready, .bus_clock_source_select, .rc_freq_change,
      .stop_request, .stop_mode, .wdt_reset_req);
   wdw_osc_model osc (.clk, .reset_n, .stop_mode, .rc_osc_enable, .main_osc_enable,
      .sub_osc_enable, .rc_clock_ready, .main_clock_ready, .sub_clock_ready, .rc_osc_tick,
      .main_osc_tick, .sub_osc_tick);

   // ==========================================
   // Checking and closing
   task automatic stop_test();
      $display("errors %0d checked %0d", errors, checked);
      if (errors == 0 && checked > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : stop_test
   task automatic hung();
      errors++;
      $display("MISMATCH %0t no answer", $time);
      stop_test();
   endtask : hung
   task automatic ck(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         errors++;
         $display("MISMATCH %0t got %h exp %h", $time, got, exp);
      end
   endtask : ck
   // ==========================================
   // Bus cycles
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      int n;
      s_axi_awaddr <= a;
      s_axi_wdata <= {24'h0, d};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      n = 0;
      do begin
         @(posedge clk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
         n++;
      end while (!s_axi_bvalid && n < 50);
      s_axi_bready <= 1'b0;
      if (n >= 50) hung();
      ck({30'h0, s_axi_bresp}, {30'h0, (a > 8'h10) ? RESP_SLVERR : RESP_OKAY});
      @(posedge clk);
   endtask : wr
   task automatic rdck(input logic [7:0] a, input logic [31:0] exp);
      int n;
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      n = 0;
      do begin
         @(posedge clk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
         n++;
      end while (!s_axi_rvalid && n < 50);
      rd_val = s_axi_rdata;
      s_axi_rready <= 1'b0;
      if (n >= 50) hung();
      ck({30'h0, s_axi_rresp}, {30'h0, RESP_OKAY});
      ck(rd_val, exp);
      @(posedge clk);
   endtask : rdck
   // ==========================================
   // Sequences
   task automatic rst();
      reset_n <= 1'b0;
      {rc_osc_enable, main_osc_enable, sub_osc_enable, main_clock_ready, sub_clock_ready,
         stop_mode} <= 6'h3E;
      bus_clock_source_select <= CS_RC_FREE;
      repeat (16) @(posedge clk);
      reset_n <= 1'b1;
      @(posedge clk);
   endtask : rst
   task automatic go(input logic [7:0] cfg, input logic [7:0] ext, input logic [7:0] pat,
      input int dly);
      wr(ADDR_UNLOCK, UNLOCK_KEY1);
      wr(ADDR_UNLOCK, UNLOCK_KEY2);
      repeat (dly) @(posedge clk);
      wr(ADDR_CONFIG, cfg);
      wr(ADDR_EXT_CONFIG, ext);
      wr(ADDR_CLEAR, pat);
   endtask : go
   task automatic quiet(input int n);
      repeat (n) @(posedge clk);
      ck({31'h0, wdt_reset_req}, 32'h0);
   endtask : quiet
   task automatic trip(input int n);
      int k;
      for (k = 0; k < n && wdt_reset_req !== 1'b1; k++) @(posedge clk);
      ck({31'h0, wdt_reset_req}, 32'h1);
   endtask : trip
   task automatic kick(input logic [1:0] k);
      {stop_request, rc_freq_change} <= k;
      @(posedge clk);
      {stop_request, rc_freq_change} <= 2'h0;
      @(posedge clk);
   endtask : kick

   initial begin
      repeat (100000) @(posedge clk);
      hung();
   end

   initial begin
      rst();
      rdck(ADDR_CONFIG, {28'h0, UPPER_RESET});
      rdck(ADDR_EXT_CONFIG, 32'h0);
      go(8'h80, 8'h10, PATTERN_ZERO, 0);
      wr(8'h14, 8'h00);
      rdck(ADDR_CONFIG, {28'h0, UPPER_RESET});
      quiet(3900);
      wr(ADDR_CLEAR, PATTERN_ZERO);
      quiet(4000);
      trip(200);
      rst();
      wr(ADDR_CLEAR, 8'h01);
      trip(5);
      rst();
      go(8'h01, 8'h10, 8'h3C, 0);
      rdck(ADDR_CONFIG, 32'h1);
      rdck(ADDR_CLEAR, 32'h3C);
      wr(ADDR_CLEAR, 8'hC3);
      trip(5);
      rst();
      go(8'h01, 8'h10, 8'h3C, 0);
      quiet(300);
      wr(ADDR_CLEAR, 8'hC3);
      rdck(ADDR_CLEAR, 32'hC3);
      quiet(300);
      wr(ADDR_CLEAR, 8'hC3);
      quiet(5);
      trip(250);
      rst();
      go(8'h01, 8'h10, 8'h3C, 0);
      quiet(300);
      wr(ADDR_CLEAR, 8'h55);
      trip(5);
      rst();
      go(8'h01, 8'h11, PATTERN_ZERO, 0);
      quiet(300);
      wr(ADDR_CLEAR, PATTERN_ZERO);
      trip(5);
      rst();
      go(8'h00, 8'h00, PATTERN_ZERO, 300);
      trip(5);
      rst();
      main_clock_ready <= 1'b0;
      go(8'h24, 8'h00, PATTERN_ZERO, 0);
      trip(5);
      rst();
      go(8'h20, 8'h00, PATTERN_ZERO, 0);
      rc_osc_enable <= 1'b0;
      quiet(100);
      trip(200);
      rst();
      go(8'h24, 8'h00, PATTERN_ZERO, 0);
      main_osc_enable <= 1'b0;
      trip(5);
      rst();
      go(8'h14, 8'h00, PATTERN_ZERO, 0);
      kick(2'h1);
      trip(5);
      rst();
      go(8'h04, 8'h00, PATTERN_ZERO, 0);
      kick(2'h1);
      quiet(5);
      rst();
      go(8'h44, 8'h00, PATTERN_ZERO, 0);
      kick(2'h2);
      trip(5);
      rst();
      sub_clock_ready <= 1'b0;
      go(8'h34, 8'h00, PATTERN_ZERO, 0);
      trip(5);
      rst();
      go(8'h30, 8'h00, PATTERN_ZERO, 0);
      sub_osc_enable <= 1'b0;
      trip(5);
      rst();
      go(8'h00, 8'h00, PATTERN_ZERO, 0);
      kick(2'h2);
      stop_mode <= 1'b1;
      bus_clock_source_select <= CS_MAIN;
      main_clock_ready <= 1'b0;
      quiet(400);
      // Count frozen at 27, locked, waiting for clocks
      rdck(ADDR_STATUS, 32'h0700001B);
      stop_mode <= 1'b0;
      quiet(300);
      main_clock_ready <= 1'b1;
      trip(300);
      stop_test();
   end
endmodule : tb_top
